// >>> verification/bcr_pcu_model.sv
// Power control state machine model on the shared register path
`timescale 1ns/10ps
module bcr_pcu_model (
  input  wire logic       clk_sys,
  output logic            pcu_select,
  output logic            pcu_wr_b,
  output logic            pcu_wr_cfg,
  output logic      [9:0] pcu_wdata
);
  // Idle: microcontroller owns the shared registers, data line toggled away
  initial begin
    pcu_select = 1'b0;
    pcu_wr_b   = 1'b0;
    pcu_wr_cfg = 1'b0;
    pcu_wdata  = 10'h2AA;
  end
  // Take or hand back the shared path
  task automatic own(input logic sel);
    @(posedge clk_sys);
    pcu_select <= sel;
  endtask
  // One-cycle write: tgt 0 is control B, tgt 1 is config
  task automatic put(input logic tgt, input logic [9:0] d);
    @(posedge clk_sys);
    pcu_wr_b   <= !tgt;
    pcu_wr_cfg <= tgt;
    pcu_wdata  <= d;
    @(posedge clk_sys);
    pcu_wr_b   <= 1'b0;
    pcu_wr_cfg <= 1'b0;
    pcu_wdata  <= ~d;
  endtask
endmodule

// >>> verification/bcr_regs_asserts.sv
// Checker for the charger control register bank, bound to its ports
`timescale 1ns/10ps
module bcr_regs_asserts
  import bcr_pkg::*;
(
  input wire logic       clk_sys,                // System clock
  input wire logic       rst,                    // General reset
  input wire logic       rst_por,                // Power-on reset
  input wire logic       reg_wr,                 // Bus write strobe
  input wire logic       reg_rd,                 // Bus read strobe
  input wire logic       pcu_select,             // Power control owns shared path
  input wire logic       pcu_wr_b,               // Power control write, control B
  input wire logic [4:0] reg_addr,               // Bus address
  input wire logic [9:0] reg_wdata,              // Bus write data
  input wire logic [9:0] reg_rdata,              // Bus read data
  input wire logic [9:0] pcu_wdata,              // Power control write data
  input wire logic [9:0] charge_level_code,      // Level DAC code
  input wire logic       type_bias_enable,       // Type bias drive
  input wire logic       charger_enable,         // Charger on drive
  input wire logic       backup_divider_connect, // Backup divider drive
  input wire logic [1:0] backup_end_voltage_sel  // Backup end step
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || rst_por);
  // Decoded bus writes per register
  wire wr_lvl = reg_wr && reg_addr == OFF_CHARGE_LEVEL;
  wire wr_a   = reg_wr && reg_addr == OFF_CHARGER_CONTROL_A;
  wire wr_b   = reg_wr && reg_addr == OFF_CHARGER_CONTROL_B;
  wire wr_cfg = reg_wr && reg_addr == OFF_CHARGER_CONFIG && !pcu_select;
  chk_level_write: assert property (
    wr_lvl |-> ##2 charge_level_code == $past(reg_wdata, 2))
    else $error("Level code did not follow its write");
  chk_type_bias: assert property (
    wr_a |-> ##2 type_bias_enable == $past(reg_wdata[7], 2))
    else $error("Type bias did not follow control A bit 7");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 10'h000)
    else $error("Read data not zero outside a read answer");
  chk_mux_blocks: assert property (
    wr_b && pcu_select && !pcu_wr_b |-> ##2 $stable(charger_enable))
    else $error("Bus write to control B taken while power control owns it");
  chk_pcu_write: assert property (
    pcu_select && pcu_wr_b |-> ##2 charger_enable == $past(pcu_wdata[0], 2))
    else $error("Power control write to control B lost");
  chk_backup_sel: assert property (
    wr_cfg |-> ##2 backup_end_voltage_sel ==
    ($past(reg_wdata[8], 2) ? 2'h2 : {1'b0, $past(reg_wdata[7], 2)}))
    else $error("Backup step wrong");
  chk_div_reset: assert property (
    disable iff (rst_por) rst |-> ##2 !backup_divider_connect)
    else $error("Backup divider survived general reset");
  chk_level_clear: assert property (
    disable iff (rst_por) rst |-> ##2 charge_level_code == 10'h000)
    else $error("Level code survived general reset");
  // Main scenarios reached
  cov_pcu_write: cover property (pcu_select && pcu_wr_b);
  cov_gen_reset: cover property (rst && !rst_por);
  cov_backup_hi: cover property (wr_cfg && reg_wdata[8]);
endmodule
bind bcr_regs bcr_regs_asserts i_chk (.*);

// >>> verification/bcr_regs_tb.sv
// Self-checking bench for the charger control register bank
`timescale 1ns/10ps
module bcr_regs_tb;
  import bcr_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, rst_por = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic charger_present_pin = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [9:0] reg_wdata = 10'h000, reg_rdata, pcu_rdata_b, pcu_rdata_cfg, pcu_wdata;
  logic [9:0] charge_level_code;
  logic pcu_select, pcu_wr_b, pcu_wr_cfg, type_bias_enable, temp_bias_enable, dac_amp_bypass;
  logic main_divider_connect, precharge_disable, itov_gain_reduce, charge_indicator_led;
  logic pulse_radio_charge_ctrl, itov_zero_cal, pulse_radio_full_charge, charge_mode_select;
  logic charger_enable, backup_divider_connect, backup_charge_enable, itov_offset_comp_enable;
  logic [2:0] thermal_bias_level;
  logic [1:0] backup_end_voltage_sel;
  logic [3:0] itov_offset_step;
  int failures = 0, check_count = 0;
  // Output fields gathered in register bit order
  wire [7:0] ctl_a = {type_bias_enable, temp_bias_enable, thermal_bias_level, 1'b0,
                      dac_amp_bypass, main_divider_connect};
  wire [7:0] ctl_b = {precharge_disable, itov_gain_reduce, charge_indicator_led,
                      pulse_radio_charge_ctrl, itov_zero_cal, pulse_radio_full_charge,
                      charge_mode_select, charger_enable};
  wire [6:0] cfg_o = {backup_divider_connect, backup_charge_enable, itov_offset_comp_enable,
                      itov_offset_step};
  bcr_regs i_dut (.*);
  bcr_pcu_model i_pcu (.*);
  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle bus write
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle bus read, data checked in the following cycle
  task automatic rd(input logic [4:0] a, input logic [9:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Let a taken write reach the registered outputs
  task automatic lag;
    @(posedge clk_sys);
    #1;
  endtask
  // One-edge general or power-on reset
  task automatic pulse(input logic por);
    @(posedge clk_sys);
    rst <= 1'b1;
    rst_por <= por;
    @(posedge clk_sys);
    rst <= 1'b0;
    rst_por <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the roughly 125 cycles of the tests
  initial begin
    #1ms;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up;
  end
  // Test sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rst_por <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(OFF_CHARGE_LEVEL, 10'h000);
    rd(OFF_CHARGER_CONTROL_B, 10'h000);
    rd(5'h00, 10'h000);
    wr(OFF_CHARGE_LEVEL, 10'h3FF);
    lag;
    chk(charge_level_code, 10'h3FF);
    rd(OFF_CHARGE_LEVEL, 10'h3FF);
    wr(OFF_CHARGER_CONTROL_A, 10'h0FF);
    lag;
    chk({2'b00, ctl_a}, 10'h0FB);
    rd(OFF_CHARGER_CONTROL_A, 10'h0FB);
    wr(OFF_CHARGER_CONTROL_A, 10'h028);
    lag;
    chk({7'h00, thermal_bias_level}, 10'h005);
    $display("Test level and control A done");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CHARGER_CONTROL_B, 10'h001 << i);
      lag;
      chk({6'h00, ctl_b[7:4]}, (10'h001 << i) >> 4);
      chk({6'h00, ctl_b[3:0]}, (10'h001 << i) & 10'h00F);
    end
    $display("Test control B bits done");
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CHARGER_CONFIG, {1'b0, s[1:0], 7'h7F});
      lag;
      chk({8'h00, backup_end_voltage_sel}, (s > 1) ? 10'h002 : 10'(s));
      chk({3'b000, cfg_o}, 10'h07F);
    end
    rd(OFF_CHARGER_CONFIG, 10'h1FF);
    $display("Test config done");
    pulse(1'b0);
    rd(OFF_CHARGER_CONFIG, 10'h1BF);
    rd(OFF_CHARGER_CONTROL_A, 10'h000);
    chk({9'h000, backup_divider_connect}, 10'h000);
    pulse(1'b1);
    rd(OFF_CHARGER_CONFIG, 10'h000);
    $display("Test resets done");
    i_pcu.own(1'b1);
    wr(OFF_CHARGER_CONTROL_B, 10'h0FF);
    rd(OFF_CHARGER_CONTROL_B, 10'h000);
    i_pcu.put(1'b0, 10'h081);
    i_pcu.put(1'b1, 10'h055);
    lag;
    chk(pcu_rdata_b, 10'h081);
    chk(pcu_rdata_cfg, 10'h055);
    wr(OFF_CHARGER_CONFIG, 10'h1FF);
    rd(OFF_CHARGER_CONFIG, 10'h055);
    wr(OFF_CHARGE_LEVEL, 10'h2A5);
    rd(OFF_CHARGE_LEVEL, 10'h2A5);
    i_pcu.own(1'b0);
    i_pcu.put(1'b0, 10'h0F0);
    rd(OFF_CHARGER_CONTROL_B, 10'h081);
    $display("Test shared path done");
    @(posedge clk_sys);
    charger_present_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(OFF_CHARGER_CONTROL_B, 10'h3FF);
    chk(pcu_rdata_b, 10'h3FF);
    @(posedge clk_sys);
    charger_present_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(OFF_CHARGER_CONTROL_B, 10'h081);
    $display("Test charger absent done");
    wrap_up;
  end
endmodule

// >>> verilog/bcr_pkg.sv
// Constants for the charger control register bank
package bcr_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 10;
  // Register offsets (5-bit word addresses)
  localparam logic [4:0] OFF_CHARGER_CONFIG    = 5'h0D;
  localparam logic [4:0] OFF_CHARGE_LEVEL      = 5'h19;
  localparam logic [4:0] OFF_CHARGER_CONTROL_A = 5'h1C;
  localparam logic [4:0] OFF_CHARGER_CONTROL_B = 5'h1D;
  // Reset value and read image of control B with no charger
  localparam logic [9:0] RST_ZERO = 10'h000;
  localparam logic [9:0] RD_NO_CHARGER = 10'h3FF;
  // Writable masks
  localparam logic [9:0] MASK_CTRL_A = 10'h3FB;
  localparam logic [9:0] MASK_CTRL_B = 10'h3FF;
  localparam logic [9:0] MASK_CONFIG = 10'h1FF;
  // Control A fields
  localparam int unsigned A_TYPE_BIAS  = 7;
  localparam int unsigned A_TEMP_BIAS  = 6;
  localparam int unsigned A_THERM_HI   = 5;
  localparam int unsigned A_THERM_LO   = 3;
  localparam int unsigned A_DAC_BYPASS = 1;
  localparam int unsigned A_MAIN_DIV   = 0;
  // Control B fields
  localparam int unsigned B_PRECHG_DIS = 7;
  localparam int unsigned B_GAIN_RED   = 6;
  localparam int unsigned B_LED        = 5;
  localparam int unsigned B_PULSE_CHG  = 4;
  localparam int unsigned B_ZERO_CAL   = 3;
  localparam int unsigned B_PULSE_FULL = 2;
  localparam int unsigned B_MODE_SEL   = 1;
  localparam int unsigned B_CHG_EN     = 0;
  // Config fields
  localparam int unsigned C_BK_SEL_HI  = 8;
  localparam int unsigned C_BK_SEL_LO  = 7;
  localparam int unsigned C_BK_DIV     = 6;
  localparam int unsigned C_BK_CHG     = 5;
  localparam int unsigned C_OFFS_EN    = 4;
  localparam int unsigned C_OFFS_HI    = 3;
  localparam int unsigned C_OFFS_LO    = 0;
  // Backup end-voltage offset codes and result in units of 100 mV
  localparam logic [1:0] BK_SEL_0MV   = 2'h0;
  localparam logic [1:0] BK_SEL_100MV = 2'h1;
  localparam logic [1:0] BK_STEP_0    = 2'h0;
  localparam logic [1:0] BK_STEP_1    = 2'h1;
  localparam logic [1:0] BK_STEP_2    = 2'h2;
endpackage

// >>> verilog/bcr_regs.sv
// Charger control register bank with shared power-control path
// Functional notes
// - Control A and level: microcontroller path only
// - Control B and config shared with power control
// - Direction select picks power control or microcontroller
// - Charge level: 10-bit R/W, resets zero
// - Control A bit 7: type bias enable
// - Control A bit 6: temperature bias enable
// - Control A bits 5-3: thermal bias level
// - Control A bit 1: DAC amp bypass
// - Control A bit 0: main divider connect
// - Control B bit 7: precharge disable
// - Control B bit 6: gain 10 to 4
// - Control B bit 5: charge LED enable
// - Control B bit 4: pulse radio charge control
// - Control B bit 2: pulse radio full charge
// - Control B bit 3: zero calibration allow
// - Control B bit1 mode, bit0 charger enable
// - Config bits 8-7: backup end offset select
// - Config bit 6: backup divider connect
// - Config bit 5: backup charge enable
// - Config bit 4: offset compensation enable
// - Config bits 3-0: offset N times 12.5mV
`timescale 1ns/10ps
module bcr_regs
  import bcr_pkg::*;
(
  input  wire logic              clk_sys,               // System clock, 10 MHz
  input  wire logic              rst,                   // General reset, sync high
  input  wire logic              rst_por,               // Power-on reset, sync high
  input  wire logic [ADDR_W-1:0] reg_addr,              // Register address
  input  wire logic [DATA_W-1:0] reg_wdata,             // Write data
  input  wire logic              reg_wr,                // Write strobe
  input  wire logic              reg_rd,                // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,             // Read data, cycle after strobe
  input  wire logic              pcu_select,            // High: power control owns shared
  input  wire logic              pcu_wr_b,              // Power control write, control B
  input  wire logic              pcu_wr_cfg,            // Power control write, config
  input  wire logic [DATA_W-1:0] pcu_wdata,             // Power control write data
  output logic      [DATA_W-1:0] pcu_rdata_b,           // Control B seen by power control
  output logic      [DATA_W-1:0] pcu_rdata_cfg,         // Config seen by power control
  input  wire logic              charger_present_pin,   // Charger detect, asynchronous
  output logic      [DATA_W-1:0] charge_level_code,     // Level DAC code
  output logic                   type_bias_enable,      // Battery type bias
  output logic                   temp_bias_enable,      // Temperature bias
  output logic      [2:0]        thermal_bias_level,    // Thermal bias level
  output logic                   dac_amp_bypass,        // Level DAC amp bypass
  output logic                   main_divider_connect,  // Main battery divider
  output logic                   precharge_disable,     // Precharge off
  output logic                   itov_gain_reduce,      // Gain 4 instead of 10
  output logic                   charge_indicator_led,  // Charge LED driver
  output logic                   pulse_radio_charge_ctrl, // Charge during pulse radio
  output logic                   itov_zero_cal,         // Zero calibration allow
  output logic                   pulse_radio_full_charge, // Full charge in pulse radio
  output logic                   charge_mode_select,    // Current or voltage mode
  output logic                   charger_enable,        // Charger on
  output logic      [1:0]        backup_end_voltage_sel, // Backup end step, 100 mV units
  output logic                   backup_divider_connect, // Backup divider
  output logic                   backup_charge_enable,  // Backup charging
  output logic                   itov_offset_comp_enable, // Offset compensation
  output logic      [3:0]        itov_offset_step       // Offset, N x 12.5 mV
);

  logic [DATA_W-1:0] charge_level;      // Level register
  logic [DATA_W-1:0] charger_control_a; // Control A register
  logic [DATA_W-1:0] charger_control_b; // Control B register
  logic [DATA_W-1:0] charger_config;    // Config register
  logic [2:0]        present_sync;      // Charger detect synchroniser
  logic              present;           // Filtered charger detect

  // Address decode helper
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Microcontroller strobes per register
  wire uc_wr_lvl = reg_wr && hit(reg_addr, OFF_CHARGE_LEVEL);
  wire uc_wr_a   = reg_wr && hit(reg_addr, OFF_CHARGER_CONTROL_A);
  wire uc_wr_b   = reg_wr && hit(reg_addr, OFF_CHARGER_CONTROL_B);
  wire uc_wr_cfg = reg_wr && hit(reg_addr, OFF_CHARGER_CONFIG);

  // Multiplexer on shared registers
  wire               wr_b      = pcu_select ? pcu_wr_b   : uc_wr_b;
  wire               wr_cfg    = pcu_select ? pcu_wr_cfg : uc_wr_cfg;
  wire [DATA_W-1:0]  shared_wd = pcu_select ? pcu_wdata  : reg_wdata;

  // Register image for reads; control B all ones with no charger
  wire [DATA_W-1:0] view_b = present ? charger_control_b : RD_NO_CHARGER;

  // Read mux; unmapped addresses read zero
  wire [DATA_W-1:0] next_rdata =
    hit(reg_addr, OFF_CHARGE_LEVEL)      ? charge_level      :
    hit(reg_addr, OFF_CHARGER_CONTROL_A) ? charger_control_a :
    hit(reg_addr, OFF_CHARGER_CONTROL_B) ? view_b            :
    hit(reg_addr, OFF_CHARGER_CONFIG)    ? charger_config    : RST_ZERO;

  // Charger detect synchroniser; change accepted when stages 2 and 3 agree
  always_ff @(posedge clk_sys) begin
    if (rst_por) begin
      present_sync <= 3'h0;
      present      <= 1'b0;
    end else begin
      present_sync <= {present_sync[1:0], charger_present_pin};
      if (present_sync[1] == present_sync[2]) begin
        present <= present_sync[2];
      end
    end
  end

  // Level and control A: microcontroller only
  always_ff @(posedge clk_sys) begin
    if (rst || rst_por) begin
      charge_level      <= RST_ZERO;
      charger_control_a <= RST_ZERO;
    end else begin
      if (uc_wr_lvl) begin
        charge_level <= reg_wdata;
      end
      if (uc_wr_a) begin
        charger_control_a <= reg_wdata & MASK_CTRL_A;
      end
    end
  end

  // Control B, shared path
  always_ff @(posedge clk_sys) begin
    if (rst || rst_por) begin
      charger_control_b <= RST_ZERO;
    end else if (wr_b) begin
      charger_control_b <= shared_wd & MASK_CTRL_B;
    end
  end

  // Config: power-on clears all, general reset clears divider only
  always_ff @(posedge clk_sys) begin
    if (rst_por) begin
      charger_config <= RST_ZERO;
    end else if (rst) begin
      charger_config[C_BK_DIV] <= 1'b0;
    end else if (wr_cfg) begin
      charger_config <= shared_wd & MASK_CONFIG;
    end
  end

  // Backup end step: 00->0, 01->1, 1x->2 (x100 mV)
  wire [1:0] bk_sel = charger_config[C_BK_SEL_HI:C_BK_SEL_LO];
  wire [1:0] next_bk_step = (bk_sel == BK_SEL_0MV)   ? BK_STEP_0 :
                            (bk_sel == BK_SEL_100MV) ? BK_STEP_1 : BK_STEP_2;

  // Read data and power control view, registered
  always_ff @(posedge clk_sys) begin
    if (rst || rst_por) begin
      reg_rdata     <= RST_ZERO;
      pcu_rdata_b   <= RST_ZERO;
      pcu_rdata_cfg <= RST_ZERO;
    end else begin
      reg_rdata     <= reg_rd ? next_rdata : RST_ZERO;
      pcu_rdata_b   <= view_b;
      pcu_rdata_cfg <= charger_config;
    end
  end

  // Either reset clears every control output
  // Keeps the analog side quiet while registers settle
  wire any_rst = rst || rst_por;

  // Control outputs follow their register bits one clock later
  // so every pin comes straight from a flip-flop with no decode
  // behind it; the lag is one cycle of the system clock

  // Level DAC code, whole register
  // Holds the charge target while the charger runs
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      charge_level_code <= RST_ZERO;
    end else begin
      charge_level_code <= charge_level;
    end
  end

  // Control A drives: bias sources, DAC buffer, main divider
  // Only the microcontroller path ever reaches these bits
  // Bit 2 and the top two bits have no pin behind them

  // Type bias enable, control A bit 7
  // Bias current for reading the battery type
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      type_bias_enable <= RST_ZERO[0];
    end else begin
      type_bias_enable <= charger_control_a[A_TYPE_BIAS];
    end
  end

  // Temperature bias enable, control A bit 6
  // Bias current for the battery thermal sensor
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      temp_bias_enable <= RST_ZERO[0];
    end else begin
      temp_bias_enable <= charger_control_a[A_TEMP_BIAS];
    end
  end

  // Thermal bias level, control A bits 5-3
  // One of eight sensor bias currents
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      thermal_bias_level <= RST_ZERO[2:0];
    end else begin
      thermal_bias_level <= charger_control_a[A_THERM_HI:A_THERM_LO];
    end
  end

  // Level DAC amplifier bypass, control A bit 1
  // Feeds the DAC output past its buffer
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      dac_amp_bypass <= RST_ZERO[0];
    end else begin
      dac_amp_bypass <= charger_control_a[A_DAC_BYPASS];
    end
  end

  // Main divider connect, control A bit 0
  // Puts the measurement divider on the main battery
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      main_divider_connect <= RST_ZERO[0];
    end else begin
      main_divider_connect <= charger_control_a[A_MAIN_DIV];
    end
  end

  // Control B drives: charger core settings
  // Pins follow the stored value even while no charger is seen;
  // the all-ones image with no charger applies to reads only

  // Precharge disable, control B bit 7
  // Stops the main battery precharge
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      precharge_disable <= RST_ZERO[0];
    end else begin
      precharge_disable <= charger_control_b[B_PRECHG_DIS];
    end
  end

  // Converter gain reduce, control B bit 6
  // Drops the current-to-voltage gain from 10 to 4
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      itov_gain_reduce <= RST_ZERO[0];
    end else begin
      itov_gain_reduce <= charger_control_b[B_GAIN_RED];
    end
  end

  // Charge indicator LED, control B bit 5
  // Turns on the LED driver that shows charging
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      charge_indicator_led <= RST_ZERO[0];
    end else begin
      charge_indicator_led <= charger_control_b[B_LED];
    end
  end

  // Pulse radio charge control, control B bit 4
  // Charging of the main battery while the radio bursts
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      pulse_radio_charge_ctrl <= RST_ZERO[0];
    end else begin
      pulse_radio_charge_ctrl <= charger_control_b[B_PULSE_CHG];
    end
  end

  // Zero calibration allow, control B bit 3
  // Lets the converter run its zero calibration
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      itov_zero_cal <= RST_ZERO[0];
    end else begin
      itov_zero_cal <= charger_control_b[B_ZERO_CAL];
    end
  end

  // Pulse radio full charge, control B bit 2
  // Full charging while the radio bursts
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      pulse_radio_full_charge <= RST_ZERO[0];
    end else begin
      pulse_radio_full_charge <= charger_control_b[B_PULSE_FULL];
    end
  end

  // Charge mode select, control B bit 1
  // Constant current or constant voltage charging
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      charge_mode_select <= RST_ZERO[0];
    end else begin
      charge_mode_select <= charger_control_b[B_MODE_SEL];
    end
  end

  // Charger enable, control B bit 0
  // Master switch of the charger
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      charger_enable <= RST_ZERO[0];
    end else begin
      charger_enable <= charger_control_b[B_CHG_EN];
    end
  end

  // Config drives: backup charging and offset compensation
  // A general reset keeps the stored bits except the divider bit, so
  // the other pins come back to their old values one clock after the reset ends

  // Backup end step in 100 mV units
  // Both top codes give the same 200 mV step
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      backup_end_voltage_sel <= RST_ZERO[1:0];
    end else begin
      backup_end_voltage_sel <= next_bk_step;
    end
  end

  // Backup divider connect, config bit 6
  // Cleared by either reset, so it never survives one
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      backup_divider_connect <= RST_ZERO[0];
    end else begin
      backup_divider_connect <= charger_config[C_BK_DIV];
    end
  end

  // Backup charge enable, config bit 5
  // Starts charging of the backup battery
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      backup_charge_enable <= RST_ZERO[0];
    end else begin
      backup_charge_enable <= charger_config[C_BK_CHG];
    end
  end

  // Offset compensation enable, config bit 4
  // Applies the offset step below to the converter
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      itov_offset_comp_enable <= RST_ZERO[0];
    end else begin
      itov_offset_comp_enable <= charger_config[C_OFFS_EN];
    end
  end

  // Offset step, config bits 3-0
  // Sixteen steps of 12.5 mV each
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      itov_offset_step <= RST_ZERO[3:0];
    end else begin
      itov_offset_step <= charger_config[C_OFFS_HI:C_OFFS_LO];
    end
  end

endmodule
